// ### logic/lhb_host_port.sv
/*
 * Host port front end: mode decode from straps, chip select, parallel
 * 6800/8080 strobes, serial shifter on the serial clock, reset sources
 * and the identification status word.
 * Assumes pins are asynchronous to clk and link_sclk is data line 0.
 */
`default_nettype none

module lhb_host_port #(
  parameter int FILT_CYC = lhb_pkg::RST_FILT_CYC,
  parameter int POR_CYC  = lhb_pkg::POR_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              link_sclk,
  input  wire logic              bus_mode_strap_lo,
  input  wire logic              bus_mode_strap_hi,
  input  wire logic              chip_select_active_low,
  input  wire logic              chip_select_active_high,
  input  wire logic              command_or_pixel_select,
  input  wire logic              production_id_pin,
  input  wire logic              byte_lane_select_pin,
  input  wire logic              host_strobe_a,
  input  wire logic              host_strobe_b,
  input  wire logic              ext_reset_n,
  input  wire logic [15:0]       db_in,
  output logic [15:0]            db_out,
  output logic [15:0]            db_oe,
  input  wire logic              sw_reset_cmd,
  input  wire logic              id_flag_wr,
  input  wire logic [1:0]        id_flag_data,
  input  wire logic [15:0]       pix_rd_data,
  output logic                   ctrl_clear,
  output lhb_pkg::lhb_mode_t     cfg_mode,
  output logic                   cfg_valid,
  output logic                   selected,
  output logic                   wr_valid,
  output lhb_pkg::lhb_word_t     wr_word,
  output logic                   rd_pulse,
  output logic [3:0]             id_status
);

  // Straps to mode; an unlisted 01/11 falls back to 6800 byte mode
  function automatic lhb_pkg::lhb_mode_t mode_dec(input logic [1:0] bm,
                                                  input logic [1:0] sv);
    if (bm == lhb_pkg::BM_6800_16) begin
      mode_dec = lhb_pkg::LHB_M68_16;
    end else if (bm == lhb_pkg::BM_8080_16) begin
      mode_dec = lhb_pkg::LHB_I80_16;
    end else if (!sv[1]) begin
      mode_dec = (bm == lhb_pkg::BM_6800_8) ? lhb_pkg::LHB_M68_8
                                            : lhb_pkg::LHB_I80_8;
    end else if (bm == lhb_pkg::BM_8080_8) begin
      mode_dec = (sv == lhb_pkg::SV_COMPACT) ? lhb_pkg::LHB_S8C
                                             : lhb_pkg::LHB_S8;
    end else if (sv == lhb_pkg::SV_FOUR_WIRE) begin
      mode_dec = lhb_pkg::LHB_S9;
    end else begin
      mode_dec = lhb_pkg::LHB_M68_8;
    end
  endfunction

  // Byte from the bus: even lines or the low lines
  function automatic logic [7:0] pick_byte(input logic [15:0] d, input logic lane);
    pick_byte = lane ? d[7:0]
                     : {d[14], d[12], d[10], d[8], d[6], d[4], d[2], d[0]};
  endfunction

  // Byte onto the bus, the same lanes as for writes
  function automatic logic [15:0] put_byte(input logic [7:0] b, input logic lane);
    put_byte = lane ? {8'h00, b}
                    : {1'b0, b[7], 1'b0, b[6], 1'b0, b[5], 1'b0, b[4],
                       1'b0, b[3], 1'b0, b[2], 1'b0, b[1], 1'b0, b[0]};
  endfunction

  lhb_pkg::lhb_pins_t pins_raw;
  lhb_pkg::lhb_pins_t s1_reg;
  lhb_pkg::lhb_pins_t s_reg;
  lhb_pkg::lhb_cfg_t  cfg_reg;
  lhb_pkg::lhb_cfg_t  cfg_next;
  lhb_pkg::lhb_word_t wr_word_reg;
  lhb_pkg::lhb_word_t wr_word_next;
  lhb_pkg::lhb_word_t ser_hold_reg;

  localparam int PW = $clog2(POR_CYC + 1);

  logic          cfg_valid_reg;
  logic [PW-1:0] por_cnt_reg;
  logic          por_busy;
  logic          ext_flt_n;
  logic          ctrl_clear_reg;
  logic [1:0]    id_flags_reg;
  logic [1:0]    id_pin_status_field;
  logic [15:0]   status_word;
  logic          sel_s;
  logic          sel_pin;
  logic          is_par;
  logic          is_ser;
  logic          is_8bit;
  logic          is_i80;
  logic          stb_a_q;
  logic          rd_act;
  logic          rd_act_q;
  logic          rd_start;
  logic          par_wr;
  logic          ser_wr;
  logic          wr_valid_reg;
  logic          rd_pulse_reg;
  logic          rd_oe_reg;
  logic [15:0]   rd_data_reg;
  logic [15:0]   rd_data_next;
  logic [15:0]   oe_mask;
  logic [7:0]    wr_byte;

  // Pin bundle sampled by the two-flop synchroniser
  assign pins_raw = '{cs_l: chip_select_active_low, cs_h: chip_select_active_high,
                      cd: command_or_pixel_select, stb_a: host_strobe_a,
                      stb_b: host_strobe_b,
                      bm: {bus_mode_strap_hi, bus_mode_strap_lo},
                      lane: byte_lane_select_pin, prod: production_id_pin,
                      rst_n: ext_reset_n, db: db_in};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '{rst_n: 1'b1, default: '0}; // Reset pin idles high: no false pulse
      s_reg  <= '{rst_n: 1'b1, default: '0};
    end else begin
      s1_reg <= pins_raw;
      s_reg  <= s1_reg;
    end
  end

  // External reset pin glitch filter
  lhb_rst_filter #(
    .CYC (FILT_CYC)
  ) u_rst_filter (
    .clk   (clk),
    .rst_n (rst_n),
    .pin_n (s_reg.rst_n),
    .flt_n (ext_flt_n)
  );

  // Power-on stretch keeps the clear active a while after rst_n lifts
  assign por_busy = (por_cnt_reg != PW'(POR_CYC));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg    <= '0;
      ctrl_clear_reg <= 1'b1;
    end else begin
      if (por_busy) begin
        por_cnt_reg <= por_cnt_reg + PW'(1);
      end
      ctrl_clear_reg <= por_busy || !ext_flt_n || sw_reset_cmd;
    end
  end

  // Straps are read once after each clear, then held
  assign cfg_next = '{mode: mode_dec(s_reg.bm, {s_reg.db[15], s_reg.db[13]}),
                      lane_low: s_reg.lane};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_valid_reg <= 1'b0;
      cfg_reg       <= '{mode: lhb_pkg::LHB_I80_8, lane_low: 1'b0};
    end else if (ctrl_clear_reg) begin
      cfg_valid_reg <= 1'b0;
    end else if (!cfg_valid_reg) begin
      cfg_valid_reg <= 1'b1;
      cfg_reg       <= cfg_next;
    end
  end

  // Programmable id flags are control state and clear with the rest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_flags_reg <= lhb_pkg::ID_FLAGS_RST;
    end else if (ctrl_clear_reg) begin
      id_flags_reg <= lhb_pkg::ID_FLAGS_RST;
    end else if (id_flag_wr) begin
      id_flags_reg <= id_flag_data;
    end
  end

  // Status word: pin levels and flags
  assign id_pin_status_field         = {s_reg.lane, s_reg.prod};
  assign status_word = lhb_pkg::STAT_RST
                       | (16'(id_pin_status_field) << lhb_pkg::STAT_PID_LSB)
                       | (16'(id_flags_reg) << lhb_pkg::STAT_FLG_LSB);
  assign id_status   = {id_flags_reg, id_pin_status_field};

  // Select and mode classes
  assign sel_s   = s_reg.cs_h && !s_reg.cs_l;
  assign sel_pin = chip_select_active_high && !chip_select_active_low;
  assign is_ser  = cfg_valid_reg && (cfg_reg.mode inside {lhb_pkg::LHB_S8,
                   lhb_pkg::LHB_S8C, lhb_pkg::LHB_S9});
  assign is_par  = cfg_valid_reg && !is_ser && sel_s;
  assign is_8bit = cfg_reg.mode inside {lhb_pkg::LHB_M68_8, lhb_pkg::LHB_I80_8};
  assign is_i80  = cfg_reg.mode inside {lhb_pkg::LHB_I80_16, lhb_pkg::LHB_I80_8};

  // 8080: a is write low, b is read low; 6800: a is enable, b is read
  assign par_wr   = is_par && (is_i80 ? (!stb_a_q && s_reg.stb_a)
                                      : (stb_a_q && !s_reg.stb_a && !s_reg.stb_b));
  assign rd_act   = is_par && (is_i80 ? !s_reg.stb_b : (s_reg.stb_a && s_reg.stb_b));
  assign rd_start = rd_act && !rd_act_q;

  // Write word, selector routes control or pixel
  assign wr_byte      = pick_byte(s_reg.db, cfg_reg.lane_low);
  assign wr_word_next = ser_wr ? ser_hold_reg
                      : lhb_pkg::lhb_word_t'{cd: s_reg.cd,
                          data: is_8bit ? {8'h00, wr_byte} : s_reg.db};

  // Read data: control reads return status, pixel reads the pixel port
  assign rd_data_next = !s_reg.cd ? status_word : pix_rd_data;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_a_q      <= 1'b0;
      rd_act_q     <= 1'b0;
      wr_valid_reg <= 1'b0;
      wr_word_reg  <= '0;
      rd_pulse_reg <= 1'b0;
      rd_oe_reg    <= 1'b0;
      rd_data_reg  <= '0;
    end else begin
      stb_a_q      <= s_reg.stb_a;
      rd_act_q     <= rd_act;
      wr_valid_reg <= par_wr || ser_wr;
      rd_pulse_reg <= rd_start && s_reg.cd;
      rd_oe_reg    <= rd_act;
      if (par_wr || ser_wr) begin
        wr_word_reg <= wr_word_next;
      end
      if (rd_start) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  // Drive gated by the raw select pins so release is immediate
  assign oe_mask = is_8bit ? put_byte(8'hff, cfg_reg.lane_low) : 16'hffff;
  assign db_oe   = (rd_oe_reg && sel_pin) ? oe_mask : 16'h0000;
  assign db_out  = is_8bit ? put_byte(rd_data_reg[7:0], cfg_reg.lane_low)
                           : rd_data_reg;

  // Serial side: runs on the host serial clock, framed by chip select
  logic       frame_rst_n;
  logic [1:0] scfg1_reg;
  logic [1:0] scfg_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       last_bit;
  logic       ser_tgl_reg;
  logic [2:0] tgl_sync_reg;

  // Frame ends reset the counter; the link clock may stop between frames
  assign frame_rst_n = rst_n && sel_pin;
  assign last_bit    = bit_cnt_reg == (scfg_reg[1] ? lhb_pkg::S9_LAST
                                                   : lhb_pkg::S8_LAST);

  always_ff @(posedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      scfg1_reg <= '0;
      scfg_reg  <= '0;
    end else begin
      scfg1_reg <= {cfg_reg.mode == lhb_pkg::LHB_S9, is_ser};
      scfg_reg  <= scfg1_reg;
    end
  end

  always_ff @(posedge link_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
    end else if (scfg_reg[0]) begin
      bit_cnt_reg <= last_bit ? 4'h0 : bit_cnt_reg + 4'h1;
      shift_reg   <= {shift_reg[6:0], db_in[lhb_pkg::SER_DATA_LINE]};
    end
  end

  // Finished token held stable while the toggle crosses to clk
  always_ff @(posedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_hold_reg <= '0;
      ser_tgl_reg  <= 1'b0;
    end else if (scfg_reg[0] && sel_pin && last_bit) begin
      ser_tgl_reg       <= !ser_tgl_reg;
      ser_hold_reg.data <= {8'h00, shift_reg[6:0], db_in[lhb_pkg::SER_DATA_LINE]};
      ser_hold_reg.cd   <= scfg_reg[1] ? shift_reg[7]
                                       : command_or_pixel_select;
    end
  end

  // Toggle synchroniser; only the last two stages feed the pulse
  assign ser_wr = is_ser && (tgl_sync_reg[2] != tgl_sync_reg[1]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_reg <= '0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], ser_tgl_reg};
    end
  end

  assign ctrl_clear = ctrl_clear_reg;
  assign cfg_mode   = cfg_reg.mode;
  assign cfg_valid  = cfg_valid_reg;
  assign selected   = sel_s;
  assign wr_valid   = wr_valid_reg;
  assign wr_word    = wr_word_reg;
  assign rd_pulse   = rd_pulse_reg;

  wide_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cfg_valid_reg) && $past(s_reg.bm) == 2'h3 |-> cfg_reg.mode == lhb_pkg::LHB_M68_16)
    else $error("strap 11 did not give 6800 wide mode");

  serial_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cfg_valid_reg) && $past(s_reg.bm) == 2'h1 && $past(s_reg.db[15])
    && !$past(s_reg.db[13]) |-> cfg_reg.mode == lhb_pkg::LHB_S9)
    else $error("strap 01 with variant 10 did not give nine-bit serial");

  bus_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    !sel_pin |-> db_oe == 16'h0000)
    else $error("data bus driven while deselected");

  clear_regs_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_clear_reg |=> id_flags_reg == lhb_pkg::ID_FLAGS_RST && !cfg_valid_reg)
    else $error("clear left control state set");

  ext_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_flt_n |=> ctrl_clear_reg)
    else $error("filtered external reset did not raise the clear");

  byte_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
    par_wr && is_8bit && cfg_reg.lane_low |=> wr_valid && wr_word.data
    == {8'h00, $past(s_reg.db[7:0])})
    else $error("low-lane byte write took the wrong lines");

  cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_valid_reg && $past(cfg_valid_reg) |-> $stable(cfg_reg))
    else $error("configuration changed while in use");

  status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_start && !s_reg.cd |=> rd_data_reg[1:0] == $past(id_pin_status_field) && !rd_pulse)
    else $error("control read did not return the id pin levels");

  strobe_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_ser |-> !par_wr && !rd_act ##1 db_oe == 16'h0000)
    else $error("strobes acted in a serial mode");

endmodule

`default_nettype wire

// ### logic/lhb_pkg.sv
/*
 * Shared constants and types for the host-port mode selector: bus mode
 * straps, timing counts, status field layout and the carrier structs.
 * Assumes a 25 MHz core clock; the serial clock arrives on data line 0.
 */
// Notes on behaviour
// - Strap 11 is 6800 16-bit, 10 is 8080 16-bit
// - Strap 01/00 with variant 0x: 8-bit 6800/8080
// - Strap 00: variant 10 four-wire, 11 compact serial
// - Strap 01 with variant 10: nine-bit serial
// - Selected only when high select high, low select low
// - Unselected device releases all sixteen data lines
// - External reset low clears every control register
// - Internal power-on and software reset also clear
// - External reset pin is filtered inside the device
// - Selector low means control, high means pixel data
// - Nine-bit serial ignores the selector pin
// - Byte mode: lane pin 0 even lines, 1 low lines
// - Status field reports the two identification pin levels
// - Four readable id bits: pins plus two flags
// - Strobe meaning follows 6800 or 8080 style
// - Serial modes ignore both strobe pins
`default_nettype none

package lhb_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RST_FILT_NS   = 1000;
  localparam int RST_FILT_CYC  = (RST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_NS        = 2000;
  localparam int POR_CYC       = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus mode strap codes
  localparam logic [1:0] BM_6800_16 = 2'h3;
  localparam logic [1:0] BM_8080_16 = 2'h2;
  localparam logic [1:0] BM_6800_8  = 2'h1;
  localparam logic [1:0] BM_8080_8  = 2'h0;

  // Serial variant strap codes
  localparam logic [1:0] SV_FOUR_WIRE = 2'h2;
  localparam logic [1:0] SV_COMPACT   = 2'h3;

  // Serial pin positions and token lengths
  localparam int SER_CLK_LINE  = 0;
  localparam int SER_DATA_LINE = 8;
  localparam logic [3:0] S8_LAST = 4'h7;
  localparam logic [3:0] S9_LAST = 4'h8;

  // Reset values and status layout
  localparam logic [1:0]  ID_FLAGS_RST = 2'h0;
  localparam int          STAT_PID_LSB = 0;
  localparam int          STAT_FLG_LSB = 2;
  localparam logic [15:0] STAT_RST     = 16'h0000;

  typedef enum logic [6:0] {
    LHB_M68_16 = 7'h01,
    LHB_I80_16 = 7'h02,
    LHB_M68_8  = 7'h04,
    LHB_I80_8  = 7'h08,
    LHB_S8     = 7'h10,
    LHB_S8C    = 7'h20,
    LHB_S9     = 7'h40
  } lhb_mode_t;

  typedef struct packed {
    lhb_mode_t mode;
    logic      lane_low;
  } lhb_cfg_t;

  typedef struct packed {
    logic        cd;
    logic [15:0] data;
  } lhb_word_t;

  typedef struct packed {
    logic        cs_l;
    logic        cs_h;
    logic        cd;
    logic        stb_a;
    logic        stb_b;
    logic [1:0]  bm;
    logic        lane;
    logic        prod;
    logic        rst_n;
    logic [15:0] db;
  } lhb_pins_t;

endpackage

`default_nettype wire

// ### logic/lhb_rst_filter.sv
/*
 * Noise filter for the external reset pin: two-flop synchroniser, then
 * a counter that accepts a new level only after it has stood steady.
 * Assumes the pin is asynchronous to clk.
 */
`default_nettype none

module lhb_rst_filter #(
  parameter int CYC = lhb_pkg::RST_FILT_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_n,
  output logic      flt_n
);

  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic          s1_reg;
  logic          s2_reg;
  logic          flt_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          flip;

  // Pulses shorter than the count never reach the output
  assign flip     = (s2_reg != flt_reg) && (cnt_reg == LAST);
  assign cnt_next = (s2_reg == flt_reg || flip) ? '0 : cnt_reg + CW'(1);
  assign flt_n    = flt_reg;

  // Synchroniser and steady-level counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      flt_reg <= 1'b1;
      cnt_reg <= '0;
    end else begin
      s1_reg  <= pin_n;
      s2_reg  <= s1_reg;
      cnt_reg <= cnt_next;
      if (flip) begin
        flt_reg <= s2_reg;
      end
    end
  end

  filt_steady_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(flt_reg) |-> $past(cnt_reg) == LAST && $past(s2_reg) == flt_reg)
    else $error("reset filter output moved before the level stood steady");

endmodule

`default_nettype wire

// ### tb/lhb_host_model.sv
/*
 * Host partner for the host port: straps, chip selects, 6800 or 8080
 * style parallel cycles and serial tokens on a 160 ns serial clock.
 * Assumes the bench resolves the data bus from host_oe and the port's
 * own output enables.
 */
`default_nettype none

module lhb_host_model (
  input  wire logic        clk,
  output logic             cs_l,
  output logic             cs_h,
  output logic             cd,
  output logic             stb_a,
  output logic             stb_b,
  output logic [1:0]       bm,
  output logic             lane,
  output logic             prod,
  output logic             host_oe,
  output logic [15:0]      host_db,
  input  wire logic [15:0] bus,
  input  wire logic [15:0] oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m68;

  // Quiet pins at time zero
  initial begin
    {cs_l, cs_h, cd, stb_a, stb_b, bm, lane, prod, m68} = 10'h200;
    host_oe = 1'b1;
    host_db = 16'h0000;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Straps stay on lines 15 and 13 until the port latches them
  task automatic strap(input logic [1:0] m, input logic [1:0] sv, input logic ln);
    @(negedge clk);
    bm = m;
    lane = ln;
    prod = ~ln;
    m68 = m[0];
    host_db = {sv[1], 1'b0, sv[0], 13'h0000};
    host_oe = 1'b1;
    stb_a = ~m[1] & sv[1] ? 1'b0 : ~m68;
    stb_b = ~(~m[1] & sv[1]);
  endtask

  task automatic sel(input logic h, input logic l);
    @(negedge clk);
    cs_h = h;
    cs_l = l;
  endtask

  // Write: 8080 takes it on the rising write strobe, 6800 on falling enable
  task automatic wr(input logic c, input logic [15:0] d);
    @(negedge clk);
    cd = c;
    host_db = d;
    host_oe = 1'b1;
    stb_b = ~m68;
    idle(4);
    stb_a = ~stb_a;
    idle(4);
    stb_a = ~stb_a;
    idle(4);
    host_oe = 1'b0;
    stb_b = 1'b1;
  endtask

  // Read: bus and enables sampled while the read phase stands
  task automatic rd(input logic c, output logic [15:0] d, output logic [15:0] oe_seen);
    @(negedge clk);
    cd = c;
    host_oe = 1'b0;
    if (m68) stb_a = 1'b1;
    else stb_b = 1'b0;
    idle(8);
    d = bus;
    oe_seen = oe_in;
    if (m68) stb_a = 1'b0;
    else stb_b = 1'b1;
    idle(6);
  endtask

  // Strobes wiggled in a serial mode, where they must not count
  task automatic wiggle();
    stb_a = 1'b1;
    stb_b = 1'b1;
    idle(4);
    stb_a = 1'b0;
    stb_b = 1'b0;
    idle(4);
  endtask

  // Token MSB first: clock on line 0, data on line 8; clock rests low
  task automatic token(input int n, input logic [8:0] v);
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      #80;
      host_db[8:0] = {v[i], 8'h00};
      #80;
      host_db[0] = 1'b1;
    end
    #80;
    host_db[0] = 1'b0;
  endtask
endmodule

`default_nettype wire

// ### tb/tb_top.sv
/*
 * Self-checking bench for the host port: mode straps, parallel writes
 * and reads, select and release, serial tokens and reset sources.
 * Assumes the host model on the far side; short reset counts.
 */
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FILT = 3;
  localparam int POR  = 4;
  logic               clk = 1'b0;
  logic               rst_n, ext_reset_n, sw_reset_cmd, id_flag_wr;
  logic               cs_l, cs_h, cd, stb_a, stb_b, lane, prod, host_oe;
  logic               ctrl_clear, cfg_valid, selected, wr_valid, rd_pulse;
  logic [1:0]         bm, id_flag_data;
  logic [3:0]         id_status;
  logic [15:0]        host_db, db_in, db_out, db_oe, pix_rd_data, rd_d, rd_oe;
  lhb_pkg::lhb_mode_t cfg_mode;
  lhb_pkg::lhb_word_t wr_word, last_w;
  int                 wr_cnt = 0, rd_cnt = 0, clr_cnt = 0, cyc = 0;
  int                 fails = 0, check_count = 0;

  always #20 clk = ~clk;

  // Released lines show the inverse of the last host value, not a hold
  assign db_in = (db_oe & db_out) | (~db_oe & (host_oe ? host_db : ~host_db));

  lhb_host_model i_lhb_host_model (.clk(clk), .cs_l(cs_l), .cs_h(cs_h), .cd(cd),
    .stb_a(stb_a), .stb_b(stb_b), .bm(bm), .lane(lane), .prod(prod),
    .host_oe(host_oe), .host_db(host_db), .bus(db_in), .oe_in(db_oe));

  lhb_host_port #(.FILT_CYC(FILT), .POR_CYC(POR)) i_lhb_host_port (.clk(clk),
    .rst_n(rst_n), .link_sclk(db_in[0]), .bus_mode_strap_lo(bm[0]),
    .bus_mode_strap_hi(bm[1]), .chip_select_active_low(cs_l),
    .chip_select_active_high(cs_h), .command_or_pixel_select(cd),
    .production_id_pin(prod), .byte_lane_select_pin(lane), .host_strobe_a(stb_a),
    .host_strobe_b(stb_b), .ext_reset_n(ext_reset_n), .db_in(db_in), .db_out(db_out),
    .db_oe(db_oe), .sw_reset_cmd(sw_reset_cmd), .id_flag_wr(id_flag_wr),
    .id_flag_data(id_flag_data), .pix_rd_data(pix_rd_data), .ctrl_clear(ctrl_clear),
    .cfg_mode(cfg_mode), .cfg_valid(cfg_valid), .selected(selected),
    .wr_valid(wr_valid), .wr_word(wr_word), .rd_pulse(rd_pulse), .id_status(id_status));

  // One-cycle pulses are counted here so no scenario can miss them
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      last_w <= wr_word;
    end
    if (rd_pulse === 1'b1) rd_cnt <= rd_cnt + 1;
    if (ctrl_clear === 1'b1) clr_cnt <= clr_cnt + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cfg();
    for (int n = 0; n < 200 && cfg_valid !== 1'b1; n++) @(negedge clk);
    chk(cfg_valid, 1'b1);
  endtask

  // Strap, hold reset 16 cycles, then expect the one-hot mode
  task automatic t_mode(input logic [1:0] m, input logic [1:0] sv, input logic ln,
                        input logic [6:0] em);
    i_lhb_host_model.strap(m, sv, ln);
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    chk(ctrl_clear, 1'b1);
    chk(cfg_valid, 1'b0);
    rst_n = 1'b1;
    wait_cfg();
    chk(cfg_mode, em);
  endtask

  task automatic s_modes();
    logic [1:0] mt[7] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1};
    logic [1:0] st[7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    for (int i = 0; i < 7; i++) t_mode(mt[i], st[i], 1'b0, 7'h01 << i);
  endtask

  // 8080 16-bit: both selector values, status and pixel reads, select
  task automatic s_par16();
    int w0;
    t_mode(2'h2, 2'h0, 1'b0, 7'h02);
    i_lhb_host_model.sel(1'b1, 1'b0);
    @(negedge clk);
    id_flag_wr = 1'b1;
    id_flag_data = 2'h2;
    @(negedge clk);
    id_flag_wr = 1'b0;
    i_lhb_host_model.wr(1'b0, 16'h1234);
    chk(last_w, 17'h01234);
    i_lhb_host_model.wr(1'b1, 16'hbeef);
    chk(last_w, 17'h1beef);
    chk(wr_cnt, 2);
    chk(cfg_mode, 7'h02);
    i_lhb_host_model.rd(1'b0, rd_d, rd_oe);
    chk(rd_d, 16'h0009);
    chk(rd_oe, 16'hffff);
    chk(id_status, 4'h9);
    i_lhb_host_model.rd(1'b1, rd_d, rd_oe);
    chk(rd_d, 16'h5a3c);
    chk(rd_cnt, 1);
    chk(db_oe, 16'h0000);
    w0 = wr_cnt;
    i_lhb_host_model.sel(1'b1, 1'b1);
    i_lhb_host_model.wr(1'b0, 16'h0f0f);
    i_lhb_host_model.rd(1'b0, rd_d, rd_oe);
    chk(rd_oe, 16'h0000);
    i_lhb_host_model.sel(1'b0, 1'b0);
    i_lhb_host_model.wr(1'b0, 16'h0f0f);
    i_lhb_host_model.rd(1'b0, rd_d, rd_oe);
    chk(rd_oe, 16'h0000);
    chk(wr_cnt, w0);
  endtask

  // Byte modes: lane 0 takes even lines, lane 1 lines 7 to 0
  task automatic s_par8();
    t_mode(2'h1, 2'h0, 1'b0, 7'h04);
    i_lhb_host_model.sel(1'b1, 1'b0);
    i_lhb_host_model.wr(1'b1, 16'heebb); // Byte a5 on even lines, odd lines noisy
    chk(last_w, 17'h100a5);
    i_lhb_host_model.rd(1'b0, rd_d, rd_oe);
    chk(rd_d, 16'h0001);
    chk(rd_oe, 16'h5555);
    t_mode(2'h1, 2'h0, 1'b1, 7'h04);
    i_lhb_host_model.sel(1'b1, 1'b0);
    i_lhb_host_model.wr(1'b0, 16'hc35a);
    chk(last_w, 17'h0005a);
    t_mode(2'h0, 2'h1, 1'b1, 7'h08);
    i_lhb_host_model.sel(1'b1, 1'b0);
    i_lhb_host_model.wr(1'b1, 16'h12c7);
    chk(last_w, 17'h100c7);
  endtask

  // Serial: dummy edges, strobes ignored, a cut token, then one whole
  task automatic s_ser(input logic [1:0] m, input logic [1:0] sv, input logic [6:0] em,
                       input logic c, input int n, input logic [8:0] v,
                       input logic [16:0] ew);
    int w0;
    t_mode(m, sv, 1'b0, em);
    i_lhb_host_model.sel(1'b0, 1'b1);
    i_lhb_host_model.token(8, 9'h0ff);
    i_lhb_host_model.sel(1'b1, 1'b0);
    i_lhb_host_model.cd = c;
    w0 = wr_cnt;
    i_lhb_host_model.wiggle();
    i_lhb_host_model.token(4, 9'h00f);
    i_lhb_host_model.sel(1'b0, 1'b1);
    i_lhb_host_model.sel(1'b1, 1'b0);
    i_lhb_host_model.token(n, v);
    repeat (10) @(negedge clk);
    chk(wr_cnt, w0 + 1);
    chk(last_w, ew);
  endtask

  // Filtered reset pin, then the software reset request
  task automatic s_reset();
    int c0;
    @(negedge clk);
    id_flag_wr = 1'b1;
    id_flag_data = 2'h3;
    @(negedge clk);
    id_flag_wr = 1'b0;
    chk(id_status[3:2], 2'h3);
    c0 = clr_cnt;
    ext_reset_n = 1'b0;
    @(negedge clk);
    ext_reset_n = 1'b1;
    repeat (12) @(negedge clk);
    chk(clr_cnt, c0);
    chk(id_status[3:2], 2'h3);
    ext_reset_n = 1'b0;
    repeat (12) @(negedge clk);
    chk(ctrl_clear, 1'b1);
    chk(id_status[3:2], 2'h0);
    ext_reset_n = 1'b1;
    wait_cfg();
    c0 = clr_cnt;
    sw_reset_cmd = 1'b1;
    @(negedge clk);
    sw_reset_cmd = 1'b0;
    repeat (3) @(negedge clk);
    chk(clr_cnt > c0, 1'b1);
    wait_cfg();
  endtask

  task automatic end_of_test();
    $display("check_count=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {rst_n, ext_reset_n, sw_reset_cmd, id_flag_wr, id_flag_data} = 6'h10;
    pix_rd_data = 16'h5a3c;
    s_modes();
    s_par16();
    s_par8();
    s_ser(2'h0, 2'h2, 7'h10, 1'b1, 8, 9'h03c, 17'h1003c);
    s_ser(2'h0, 2'h3, 7'h20, 1'b0, 8, 9'h081, 17'h00081);
    s_ser(2'h1, 2'h2, 7'h40, 1'b1, 9, 9'h0a5, 17'h000a5);
    s_reset();
    end_of_test();
  end
endmodule

`default_nettype wire
